// ---- ancm_pkg.sv ----
// Constants and types for the auto-negotiation management block
`default_nettype none
package ancm_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_ATTACH = 8'h08;
   localparam logic [7:0] OFF_ADV_ABIL = 8'h0C;
   localparam logic [7:0] OFF_ADV_SEL = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_PARTNER = 8'h18;
   localparam logic [7:0] OFF_LOCAL = 8'h1C;
   localparam logic [7:0] OFF_INDEX = 8'h20;

   // ----------------------------------------------------------------
   // Field widths and positions
   // ----------------------------------------------------------------
   localparam int ABIL_W = 8;
   localparam int SEL_W = 5;
   localparam int TYPE_W = 8;
   localparam int IDX_W = 16;
   localparam int CTRL_ADMIN_BIT = 0;
   localparam int CMD_RESTART_BIT = 0;
   localparam int CMD_ON_BIT = 1;
   localparam int CMD_OFF_BIT = 2;
   localparam int STAT_FAR_BIT = 5;
   localparam int STAT_REJ_ABIL_BIT = 6;
   localparam int STAT_REJ_SEL_BIT = 7;
   localparam int SEL_LSB = 8;

   // ----------------------------------------------------------------
   // Ability bits: 10T, 10T-FD, 100TX, 100TX-FD, 100T4, other,
   // unknown, reserved; selector codes
   // ----------------------------------------------------------------
   localparam logic [7:0] LOCAL_ABIL = 8'h1F;
   localparam logic [4:0] SEL_OTHER = 5'h00;
   localparam logic [4:0] SEL_ETHERNET = 5'h01;
   localparam logic [4:0] SEL_ISOLAN = 5'h02;
   localparam logic [4:0] LOCAL_SEL = SEL_ETHERNET;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_ADMIN = 1'b1;
   localparam logic [7:0] RST_ATTACH = 8'h00;
   localparam logic [7:0] RST_ADV_ABIL = LOCAL_ABIL;
   localparam logic [4:0] RST_ADV_SEL = LOCAL_SEL;
   localparam logic [15:0] OBJ_INDEX = 16'h0001;

   // Negotiation progress, one-hot
   typedef enum logic [4:0] {
      ANCM_OTHER = 5'h01,
      ANCM_CONFIG = 5'h02,
      ANCM_COMPLETE = 5'h04,
      ANCM_DISABLED = 5'h08,
      ANCM_PDFAIL = 5'h10
   } ancm_prog_t;

   // Address match for one register
   function automatic logic ancm_hit(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction : ancm_hit

   // Every requested ability must be one the hardware has
   function automatic logic ancm_abil_ok(input logic [7:0] req);
      return (req & ~LOCAL_ABIL) == 8'h00;
   endfunction : ancm_abil_ok
endpackage : ancm_pkg
`default_nettype wire

// ---- ancm_rx_if.sv ----
// Received link code word and partner store between core and store
`timescale 1ns/100ps
`default_nettype none
interface ancm_rx_if;
   logic rx_valid;
   logic [ancm_pkg::ABIL_W-1:0] rx_ability;
   logic [ancm_pkg::SEL_W-1:0] rx_selector;
   logic [ancm_pkg::ABIL_W-1:0] partner_ability;
   logic [ancm_pkg::SEL_W-1:0] partner_selector;
   modport core (output rx_valid, rx_ability, rx_selector,
                 input partner_ability, partner_selector);
   modport store (input rx_valid, rx_ability, rx_selector,
                  output partner_ability, partner_selector);
endinterface : ancm_rx_if
`default_nettype wire

// ---- ancm_partner_store.sv ----
// Holds the partner fields of the last received link code word
`timescale 1ns/100ps
`default_nettype none
module ancm_partner_store
(
   input wire logic pclk,
   input wire logic presetn,
   ancm_rx_if.store rx
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx.partner_ability <= '0;
         rx.partner_selector <= '0;
      end
      else if (rx.rx_valid)
      begin
         rx.partner_ability <= rx.rx_ability;
         rx.partner_selector <= rx.rx_selector;
      end
   end

   a_partner_latch: assert property (@(posedge pclk) disable iff (!presetn)
      rx.rx_valid |=> rx.partner_ability == $past(rx.rx_ability)
                      && rx.partner_selector == $past(rx.rx_selector))
      else $error("partner fields not taken from last word");
endmodule : ancm_partner_store
`default_nettype wire

// ---- ancm_babble.sv ----
// One-cycle alert on entry into the jabber state
`timescale 1ns/100ps
`default_nettype none
module ancm_babble
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic jabber_state,
   output logic babble_alert
);
   logic jabber_prev;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         jabber_prev <= 1'b0;
         babble_alert <= 1'b0;
      end
      else
      begin
         jabber_prev <= jabber_state;
         babble_alert <= jabber_state & ~jabber_prev;
      end
   end

   a_babble_entry: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(jabber_state) |=> babble_alert ##1 !babble_alert)
      else $error("jabber entry did not give one alert pulse");
endmodule : ancm_babble
`default_nettype wire

// ---- ancm_autoneg_mgmt.sv ----
// APB management of link auto-negotiation: admin, adverts, status
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ancm_autoneg_mgmt
#(
   parameter bit HAS_AN = 1'b1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_word_valid,
   input wire logic [ancm_pkg::ABIL_W-1:0] rx_ability,
   input wire logic [ancm_pkg::SEL_W-1:0] rx_selector,
   input wire logic flp_burst_seen,
   input wire logic neg_done,
   input wire logic pd_fail,
   input wire logic jabber_state,
   output logic an_enable,
   output logic forced_mode,
   output logic renegotiate_pulse,
   output logic [ancm_pkg::ABIL_W-1:0] tx_ability,
   output logic [ancm_pkg::SEL_W-1:0] tx_selector,
   output logic [ancm_pkg::TYPE_W-1:0] attach_type,
   output logic babble_alert
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic admin;
   logic next_admin;
   logic flp_pending;
   logic far_flag;
   logic rej_abil;
   logic rej_sel;
   ancm_pkg::ancm_prog_t prog;
   logic setup;
   logic wr;
   logic wr_ctrl;
   logic wr_cmd;
   logic wr_abil;
   logic wr_sel;
   logic abil_ok;
   logic sel_ok;
   logic adv_ok;
   logic restart_req;
   logic mapped;
   logic [31:0] rd_val;

   ancm_rx_if rx ();

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Writes land at the access edge, when pready is high
   assign setup = psel & ~penable;
   assign wr = psel & penable & pready & pwrite;
   assign wr_ctrl = wr & ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_CTRL);
   assign wr_cmd = wr & ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_CMD);
   assign wr_abil = wr & ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ADV_ABIL);
   assign wr_sel = wr & ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ADV_SEL);

   assign abil_ok = ancm_pkg::ancm_abil_ok(pwdata[ancm_pkg::ABIL_W-1:0]);
   assign sel_ok = pwdata[ancm_pkg::SEL_W-1:0] == ancm_pkg::LOCAL_SEL;
   assign adv_ok = (wr_abil & abil_ok) | (wr_sel & sel_ok);

   assign mapped = ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_CTRL)
                 | ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_CMD)
                 | ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ATTACH)
                 | ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ADV_ABIL)
                 | ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ADV_SEL)
                 | ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_STATUS)
                 | ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_PARTNER)
                 | ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_LOCAL)
                 | ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_INDEX);

   // ----------------------------------------------------------------
   // Admin state and restart
   // ----------------------------------------------------------------
   // on/off action acts like a direct write; both bits is a no-op
   always_comb
   begin
      next_admin = admin;
      if (wr_ctrl)
         next_admin = pwdata[ancm_pkg::CTRL_ADMIN_BIT];
      else if (wr_cmd && pwdata[ancm_pkg::CMD_ON_BIT] && !pwdata[ancm_pkg::CMD_OFF_BIT])
         next_admin = 1'b1;
      else if (wr_cmd && pwdata[ancm_pkg::CMD_OFF_BIT] && !pwdata[ancm_pkg::CMD_ON_BIT])
         next_admin = 1'b0;
   end

   // restart action; accepted advert; nothing while off
   // Turning negotiation on also starts a fresh exchange
   assign restart_req = next_admin
                      & (~admin | (wr_cmd & pwdata[ancm_pkg::CMD_RESTART_BIT]) | adv_ok);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         admin <= ancm_pkg::RST_ADMIN;
      else
         admin <= next_admin;
   end

   // engine enabled only when able; otherwise forced mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         an_enable <= ancm_pkg::RST_ADMIN & HAS_AN;
         forced_mode <= ~(ancm_pkg::RST_ADMIN & HAS_AN);
         renegotiate_pulse <= 1'b0;
      end
      else
      begin
         an_enable <= next_admin & HAS_AN;
         forced_mode <= ~(next_admin & HAS_AN);
         renegotiate_pulse <= restart_req & HAS_AN;
      end
   end

   // ----------------------------------------------------------------
   // Settings
   // ----------------------------------------------------------------
   // attachment type is driven out as soon as it is written
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         attach_type <= ancm_pkg::RST_ATTACH;
      else if (wr & ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ATTACH))
         attach_type <= pwdata[ancm_pkg::TYPE_W-1:0];
   end

   // adverts drive the outgoing word; rejects keep old value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_ability <= ancm_pkg::RST_ADV_ABIL;
         tx_selector <= ancm_pkg::RST_ADV_SEL;
      end
      else
      begin
         if (wr_abil && abil_ok)
            tx_ability <= pwdata[ancm_pkg::ABIL_W-1:0];
         if (wr_sel && sel_ok)
            tx_selector <= pwdata[ancm_pkg::SEL_W-1:0];
      end
   end

   // Last-write outcome, so software can see a refused advert
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rej_abil <= 1'b0;
         rej_sel <= 1'b0;
      end
      else
      begin
         if (wr_abil)
            rej_abil <= ~abil_ok;
         if (wr_sel)
            rej_sel <= ~sel_ok;
      end
   end

   // ----------------------------------------------------------------
   // Progress
   // ----------------------------------------------------------------
   // progress; a restart always wins over engine reports
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prog <= ancm_pkg::ANCM_CONFIG;
      else if (!next_admin || !HAS_AN)
         prog <= ancm_pkg::ANCM_DISABLED;
      else if (restart_req)
         prog <= ancm_pkg::ANCM_CONFIG;
      else
      begin
         unique case (prog)
            ancm_pkg::ANCM_CONFIG:
            begin
               if (pd_fail)
                  prog <= ancm_pkg::ANCM_PDFAIL;
               else if (neg_done)
                  prog <= ancm_pkg::ANCM_COMPLETE;
            end
            ancm_pkg::ANCM_COMPLETE:
            begin
               if (pd_fail)
                  prog <= ancm_pkg::ANCM_PDFAIL;
            end
            ancm_pkg::ANCM_OTHER,
            ancm_pkg::ANCM_DISABLED,
            ancm_pkg::ANCM_PDFAIL:
               prog <= prog;
         endcase
      end
   end

   // bursts are collected per negotiation, published when it ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flp_pending <= 1'b0;
         far_flag <= 1'b0;
      end
      else if (restart_req)
         flp_pending <= 1'b0;
      else if (prog == ancm_pkg::ANCM_CONFIG && next_admin)
      begin
         if (pd_fail || neg_done)
         begin
            far_flag <= flp_pending | flp_burst_seen;
            flp_pending <= 1'b0;
         end
         else if (flp_burst_seen)
            flp_pending <= 1'b1;
      end
   end

   // received words are ignored while negotiation is off
   assign rx.rx_valid = rx_word_valid & an_enable;
   assign rx.rx_ability = rx_ability;
   assign rx.rx_selector = rx_selector;

   ancm_partner_store u_partner
   (
      .pclk(pclk),
      .presetn(presetn),
      .rx(rx.store)
   );

   ancm_babble u_babble
   (
      .pclk(pclk),
      .presetn(presetn),
      .jabber_state(jabber_state),
      .babble_alert(babble_alert)
   );

   // ----------------------------------------------------------------
   // Read path and APB answer
   // ----------------------------------------------------------------
   // read views
   always_comb
   begin
      rd_val = 32'h0000_0000;
      unique case (1'b1)
         ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_CTRL):
            rd_val[ancm_pkg::CTRL_ADMIN_BIT] = admin;
         ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ATTACH):
            rd_val[ancm_pkg::TYPE_W-1:0] = attach_type;
         ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ADV_ABIL):
            rd_val[ancm_pkg::ABIL_W-1:0] = tx_ability;
         ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ADV_SEL):
            rd_val[ancm_pkg::SEL_W-1:0] = tx_selector;
         ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_STATUS):
         begin
            rd_val[4:0] = prog;
            rd_val[ancm_pkg::STAT_FAR_BIT] = far_flag;
            rd_val[ancm_pkg::STAT_REJ_ABIL_BIT] = rej_abil;
            rd_val[ancm_pkg::STAT_REJ_SEL_BIT] = rej_sel;
         end
         ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_PARTNER):
         begin
            rd_val[ancm_pkg::ABIL_W-1:0] = rx.partner_ability;
            rd_val[ancm_pkg::SEL_LSB +: ancm_pkg::SEL_W] = rx.partner_selector;
         end
         ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_LOCAL):
         begin
            rd_val[ancm_pkg::ABIL_W-1:0] = ancm_pkg::LOCAL_ABIL;
            rd_val[ancm_pkg::SEL_LSB +: ancm_pkg::SEL_W] = ancm_pkg::LOCAL_SEL;
         end
         ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_INDEX):
            rd_val[ancm_pkg::IDX_W-1:0] = ancm_pkg::OBJ_INDEX;
         default:
            rd_val = 32'h0000_0000;
      endcase
   end

   // One wait-free access phase; answer prepared during setup
   // Errors: unmapped address, or a refused advert write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & (~mapped
            | (pwrite & ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ADV_ABIL) & ~abil_ok)
            | (pwrite & ancm_pkg::ancm_hit(paddr, ancm_pkg::OFF_ADV_SEL) & ~sel_ok));
         prdata <= (setup & ~pwrite) ? rd_val : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      pready ##1 !pready;
   endsequence

   a_apb_answer: assert property (s_setup |=> s_access)
      else $error("access phase not answered in one cycle");

   a_abil_reject: assert property ((wr_abil && !abil_ok) |=>
      tx_ability == $past(tx_ability) && !renegotiate_pulse)
      else $error("refused ability write changed state");

   a_abil_accept: assert property ((wr_abil && abil_ok) |=>
      tx_ability == $past(pwdata[7:0]))
      else $error("accepted ability write not stored");

   a_sel_reject: assert property ((wr_sel && !sel_ok) |=>
      tx_selector == $past(tx_selector) && rej_sel)
      else $error("refused selector write changed value");

   a_adv_restart: assert property ((adv_ok && admin && next_admin) |=>
      renegotiate_pulse && prog == ancm_pkg::ANCM_CONFIG)
      else $error("accepted advert did not restart");

   a_restart_off: assert property ((!admin && !next_admin) |=>
      !renegotiate_pulse)
      else $error("restart issued while disabled");

   a_pd_fail: assert property ((prog == ancm_pkg::ANCM_CONFIG && pd_fail
      && next_admin && !restart_req) |=> prog == ancm_pkg::ANCM_PDFAIL)
      else $error("parallel detect failure not reported");

   a_off_forced: assert property ((!an_enable) |-> forced_mode
      && prog == ancm_pkg::ANCM_DISABLED)
      else $error("disabled but not in forced mode");

   a_on_action: assert property ((wr_cmd && pwdata[1] && !pwdata[2]) |=>
      an_enable == HAS_AN)
      else $error("on action did not enable negotiation");
endmodule : ancm_autoneg_mgmt
`default_nettype wire

// ---- ancm_link_partner.sv ----
// Link partner model that answers each renegotiation of the block that arrives while it is idle
`timescale 1ns/100ps
`default_nettype none
module ancm_link_partner
(
   input wire logic pclk,
   input wire logic renegotiate_pulse,
   input wire logic use_bursts,
   input wire logic fail,
   input wire logic slow,
   input wire logic [7:0] abil,
   input wire logic [4:0] sel,
   output logic rx_word_valid,
   output logic [7:0] rx_ability,
   output logic [4:0] rx_selector,
   output logic flp_burst_seen,
   output logic neg_done,
   output logic pd_fail,
   output logic busy
);
   logic [7:0] abil_q = 8'h00;
   logic [4:0] sel_q = 5'h00;

   // ----------------------------------------------------------------
   // Code word fields
   // ----------------------------------------------------------------
   // Outside the valid cycle the fields invert, so a late sample shows
   assign rx_ability = rx_word_valid ? abil_q : ~abil_q;
   assign rx_selector = rx_word_valid ? sel_q : ~sel_q;

   // ----------------------------------------------------------------
   // Negotiation sequence
   // ----------------------------------------------------------------
   // A pulse during a running negotiation is not seen: a real partner
   // also finishes the exchange it is in
   initial
   begin
      {rx_word_valid, flp_burst_seen, neg_done, pd_fail, busy} = 5'h00;
      forever
      begin
         @(posedge pclk);
         if (renegotiate_pulse === 1'b1)
         begin
            busy <= 1'b1;
            repeat (slow ? 12 : 2) @(posedge pclk);
            flp_burst_seen <= use_bursts;
            rx_word_valid <= 1'b1;
            abil_q <= abil;
            sel_q <= sel;
            @(posedge pclk);
            flp_burst_seen <= 1'b0;
            rx_word_valid <= 1'b0;
            neg_done <= !fail;
            pd_fail <= fail;
            @(posedge pclk);
            neg_done <= 1'b0;
            pd_fail <= 1'b0;
            busy <= 1'b0;
         end
      end
   end
endmodule : ancm_link_partner
`default_nettype wire

// ---- test_autoneg_management_control.sv ----
// Self-checking bench for the auto-negotiation management block
`timescale 1ns/100ps
`default_nettype none
module test_autoneg_management_control;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ok;
   logic rxv, flp, ndone, pdf, jab, an_en, forced, reneg, babble;
   logic use_b, fail, slow, busy, sel_bad;
   logic [7:0] paddr, rxa, txa, att, p_abil, exp_abil, v;
   logic [4:0] rxs, txs, p_sel, exp_sel, s;
   logic [31:0] pwdata, prdata, rd, seed;
   int num_errors = 0, cmp_count = 0, n_reneg = 0, n_babble = 0, exp_reneg = 0;

   ancm_autoneg_mgmt ancm_autoneg_mgmt_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_word_valid(rxv), .rx_ability(rxa), .rx_selector(rxs),
      .flp_burst_seen(flp), .neg_done(ndone), .pd_fail(pdf),
      .jabber_state(jab), .an_enable(an_en), .forced_mode(forced),
      .renegotiate_pulse(reneg), .tx_ability(txa), .tx_selector(txs),
      .attach_type(att), .babble_alert(babble));
   ancm_link_partner ancm_link_partner_inst (.pclk(pclk),
      .renegotiate_pulse(reneg), .use_bursts(use_b), .fail(fail),
      .slow(slow), .abil(p_abil), .sel(p_sel), .rx_word_valid(rxv),
      .rx_ability(rxa), .rx_selector(rxs), .flp_burst_seen(flp),
      .neg_done(ndone), .pd_fail(pdf), .busy(busy));

   // ----------------------------------------------------------------
   // Clock, pulse counters, watchdog
   // ----------------------------------------------------------------
   // Free-running 125 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Counting pulses also proves they last a single cycle
   always @(posedge pclk)
   begin
      if (reneg === 1'b1) n_reneg++;
      if (babble === 1'b1) n_babble++;
   end

   // Cuts a hang short
   initial
   begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Status after a finished negotiation, reject bits clear
   function automatic logic [31:0] st_exp(input logic f, input logic b);
      return {26'h0, b, f ? 5'h10 : 5'h04};
   endfunction : st_exp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No local limit: the watchdog ends a wait that is never answered
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdchk

   // Waits until the partner has finished its exchange
   task automatic idle();
      repeat (4) @(posedge pclk);
      while (busy === 1'b1)
         @(posedge pclk);
   endtask : idle

   task automatic tally_and_finish();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      seed = 32'h0000_F23F;
      {psel, penable, pwrite, jab, use_b, fail, slow, sel_bad} = 8'h00;
      {paddr, pwdata, p_abil, p_sel} = 53'h0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(ancm_pkg::OFF_CTRL, 32'h0000_0001);
      rdchk(ancm_pkg::OFF_STATUS, 32'h0000_0002);
      rdchk(ancm_pkg::OFF_LOCAL, 32'h0000_011F);
      rdchk(ancm_pkg::OFF_ADV_ABIL, 32'h0000_001F);
      rdchk(ancm_pkg::OFF_ADV_SEL, 32'h0000_0001);
      apb(1'b0, 8'h24, 32'h0000_0000);
      chk(err, 1'b1);
      // Every mix of bursts seen and failure; slow partner only when just one of them is set
      for (int i = 0; i < 4; i++)
      begin
         {fail, use_b} = 2'(i);
         slow = i[0] ^ i[1];
         p_abil = 8'(rnd());
         p_sel = 5'(rnd());
         apb(1'b1, ancm_pkg::OFF_CMD, 32'h0000_0001);
         exp_reneg++;
         idle();
         chk(n_reneg, exp_reneg);
         rdchk(ancm_pkg::OFF_STATUS, st_exp(fail, use_b));
         rdchk(ancm_pkg::OFF_PARTNER, {19'h0, p_sel, p_abil});
      end
      // Advert writes, refused ones among them
      exp_abil = 8'h1F;
      exp_sel = 5'h01;
      for (int i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 8'h20 : (i == 1) ? 8'h0A : 8'(rnd());
         ok = (v & ~ancm_pkg::LOCAL_ABIL) == 8'h00;
         apb(1'b1, ancm_pkg::OFF_ADV_ABIL, {24'h0, v});
         chk(err, !ok);
         if (ok) exp_abil = v;
         if (ok) exp_reneg++;
         rdchk(ancm_pkg::OFF_ADV_ABIL, {24'h0, exp_abil});
         chk(txa, exp_abil);
         apb(1'b0, ancm_pkg::OFF_STATUS, 32'h0000_0000);
         chk(rd[6], !ok);
         chk(rd[7], sel_bad);
         s = (i < 3) ? 5'(i) : 5'(rnd());
         ok = s == ancm_pkg::LOCAL_SEL;
         apb(1'b1, ancm_pkg::OFF_ADV_SEL, {27'h0, s});
         chk(err, !ok);
         sel_bad = !ok;
         if (ok) exp_sel = s;
         if (ok) exp_reneg++;
         rdchk(ancm_pkg::OFF_ADV_SEL, {27'h0, exp_sel});
         chk(txs, exp_sel);
         chk(n_reneg, exp_reneg);
      end
      idle();
      // Disabled admin state acts as a forced link
      apb(1'b1, ancm_pkg::OFF_CTRL, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      chk({an_en, forced}, 2'b01);
      apb(1'b0, ancm_pkg::OFF_STATUS, 32'h0000_0000);
      chk(rd[4:0], 5'h08);
      v = 8'(rnd());
      apb(1'b1, ancm_pkg::OFF_ATTACH, {24'h0, v});
      repeat (2) @(posedge pclk);
      chk(att, v);
      apb(1'b1, ancm_pkg::OFF_CMD, 32'h0000_0001);
      apb(1'b1, ancm_pkg::OFF_ADV_ABIL, 32'h0000_0003);
      repeat (3) @(posedge pclk);
      chk(n_reneg, exp_reneg);
      chk(txa, 8'h03);
      // On and off actions
      fail = 1'b0;
      apb(1'b1, ancm_pkg::OFF_CMD, 32'h0000_0002);
      exp_reneg++;
      idle();
      chk({an_en, forced}, 2'b10);
      chk(n_reneg, exp_reneg);
      apb(1'b0, ancm_pkg::OFF_STATUS, 32'h0000_0000);
      chk(rd[4:0], 5'h04);
      apb(1'b1, ancm_pkg::OFF_CMD, 32'h0000_0004);
      rdchk(ancm_pkg::OFF_CTRL, 32'h0000_0000);
      chk(an_en, 1'b0);
      // Jabber entries, each held several cycles
      for (int i = 0; i < 2; i++)
      begin
         jab <= 1'b1;
         repeat (6) @(posedge pclk);
         jab <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      chk(n_babble, 2);
      // Mid-run reset must restore every setting from the disabled state
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({an_en, forced, txa, txs, att}, {2'h2, 8'h1F, 5'h01, 8'h00});
      rdchk(ancm_pkg::OFF_STATUS, 32'h0000_0002);
      rdchk(ancm_pkg::OFF_CTRL, 32'h0000_0001);
      tally_and_finish();
   end
endmodule : test_autoneg_management_control
`default_nettype wire
